// ---- common/drp_pkg.sv ----
// Package for the data RAM partition register block
package drp_pkg;
    // APB byte addresses of the registers
    localparam logic [7:0] DRP_KPB_OFF = 8'h00;
    localparam logic [7:0] DRP_UDB_OFF = 8'h04;
    localparam logic [7:0] DRP_UPB_OFF = 8'h08;
    localparam logic [7:0] DRP_SIZE_OFF = 8'h0c;
    localparam int DRP_ADDR_W = 8;
    // Base field position
    localparam int DRP_BASE_LSB = 10;
    localparam int DRP_BASE_MSB = 15;
    localparam int DRP_BASE_W = DRP_BASE_MSB - DRP_BASE_LSB + 1;
    localparam logic [DRP_BASE_W-1:0] DRP_BASE_RST = 6'h00;
    // Legal size codes
    localparam logic [31:0] DRP_SIZE_4K = 32'h0000_1000;
    localparam logic [31:0] DRP_SIZE_8K = 32'h0000_2000;
    localparam logic [31:0] DRP_SIZE_16K = 32'h0000_4000;
    localparam logic [31:0] DRP_SIZE_32K = 32'h0000_8000;
    localparam int DRP_OFS_W = 15;
    // Region codes
    typedef enum logic [1:0]
    {
        DRP_KDATA = 2'b00,
        DRP_KPROG = 2'b01,
        DRP_UDATA = 2'b10,
        DRP_UPROG = 2'b11
    } drp_region_e;
endpackage

// ---- src/drp_classify.sv ----
// Region classifier for one data RAM offset
module drp_classify
    import drp_pkg::*;
(
    input wire logic [DRP_OFS_W-1:0] i_offset,
    input wire logic [DRP_BASE_W-1:0] i_kpb,
    input wire logic [DRP_BASE_W-1:0] i_udb,
    input wire logic [DRP_BASE_W-1:0] i_upb,
    output drp_region_e o_region
);
    logic [DRP_BASE_W-1:0] blk;
    // Offset is one bit short of the field, so the top compare bit is always zero
    assign blk = {1'b0, i_offset[DRP_BASE_MSB-1:DRP_BASE_LSB]};
    // A zero base means that region is absent, so all-zero leaves only kernel data
    always_comb
    begin
        o_region = DRP_KDATA;
        if (i_upb != '0 && blk >= i_upb)
            o_region = DRP_UPROG;
        else if (i_udb != '0 && blk >= i_udb)
            o_region = DRP_UDATA;
        else if (i_kpb != '0 && blk >= i_kpb)
            o_region = DRP_KPROG;
    end
endmodule

// ---- src/drp_regs.sv ----
// APB register set for the data RAM partition and access classifier
//
// Operation
// - Base bits 31-16 read zero, ignore writes
// - Kernel program base writable in bits 15:10
// - User data base writable in bits 15:10
// - User program base writable in bits 15:10
// - Base bits 9:0 read zero
// - Reset clears all bases
// - All-zero bases mean all kernel data
// - Size register read-only, ignores writes
// - Size reads 4, 8, 16 or 32 KB code
//
// The register addresses and register access over APB are this design's own decisions.
module drp_regs
    import drp_pkg::*;
#(
    parameter logic [31:0] RAM_SIZE = DRP_SIZE_32K
)
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [DRP_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [DRP_OFS_W-1:0] i_access_offset,
    output drp_region_e o_access_region,
    output logic o_access_out_of_range
);
    typedef struct packed
    {
        logic [DRP_BASE_W-1:0] kpb;
        logic [DRP_BASE_W-1:0] udb;
        logic [DRP_BASE_W-1:0] upb;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        drp_region_e region;
        logic oor;
    } drp_state_s;

    drp_state_s state;
    drp_state_s next_state;
    drp_region_e region_now;
    logic setup;
    logic wr_ok;
    logic hit;
    logic [31:0] rdata;

    drp_classify u_classify
    (
        .i_offset(i_access_offset),
        .i_kpb(state.kpb),
        .i_udb(state.udb),
        .i_upb(state.upb),
        .o_region(region_now)
    );

    // Answer one cycle after setup; pready is a pulse in the access phase
    assign setup = i_psel && !i_penable;
    // Base field lies in byte lane 1
    assign wr_ok = i_pwrite && i_pstrb[1];

    always_comb
    begin
        hit = 1'b1;
        rdata = 32'h0000_0000;
        unique case (i_paddr)
            DRP_KPB_OFF: rdata[DRP_BASE_MSB:DRP_BASE_LSB] = state.kpb;
            DRP_UDB_OFF: rdata[DRP_BASE_MSB:DRP_BASE_LSB] = state.udb;
            DRP_UPB_OFF: rdata[DRP_BASE_MSB:DRP_BASE_LSB] = state.upb;
            DRP_SIZE_OFF: rdata = RAM_SIZE;
            default: hit = 1'b0;
        endcase
    end

    always_comb
    begin
        next_state = state;
        next_state.pready = setup;
        next_state.pslverr = setup && !hit;
        next_state.prdata = (setup && !i_pwrite && hit) ? rdata : 32'h0000_0000;
        // Write lands at setup since the answer is fixed at one wait-free access
        if (setup && wr_ok)
        begin
            if (i_paddr == DRP_KPB_OFF)
                next_state.kpb = i_pwdata[DRP_BASE_MSB:DRP_BASE_LSB];
            if (i_paddr == DRP_UDB_OFF)
                next_state.udb = i_pwdata[DRP_BASE_MSB:DRP_BASE_LSB];
            if (i_paddr == DRP_UPB_OFF)
                next_state.upb = i_pwdata[DRP_BASE_MSB:DRP_BASE_LSB];
        end
        // Ordering of bases is trusted to software, so no check here
        next_state.region = region_now;
        next_state.oor = {17'h0_0000, i_access_offset} >= RAM_SIZE;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state.kpb <= DRP_BASE_RST;
            state.udb <= DRP_BASE_RST;
            state.upb <= DRP_BASE_RST;
            state.prdata <= 32'h0000_0000;
            state.pready <= 1'b0;
            state.pslverr <= 1'b0;
            state.region <= DRP_KDATA;
            state.oor <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign o_prdata = state.prdata;
    assign o_pready = state.pready;
    assign o_pslverr = state.pslverr;
    assign o_access_region = state.region;
    assign o_access_out_of_range = state.oor;
endmodule

// ---- test/drp_regs_asserts.sv ----
// Checker for the data RAM partition registers
module drp_regs_asserts
    import drp_pkg::*;
#(
    parameter logic [31:0] RAM_SIZE = DRP_SIZE_32K
)
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_pwrite,
    input wire logic [DRP_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic [DRP_OFS_W-1:0] i_access_offset,
    input wire drp_region_e o_access_region,
    input wire logic o_access_out_of_range
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    AST_HI_ZERO: assert property (o_pready |-> o_prdata[31:16] == 16'h0) else $error("high bits set");
    AST_LO_ZERO: assert property (o_pready |-> o_prdata[9:0] == 10'h0) else $error("low bits set");
    AST_SIZE: assert property (o_pready && !i_pwrite && i_paddr == DRP_SIZE_OFF |-> o_prdata == RAM_SIZE)
        else $error("bad size");
    AST_READBACK: assert property (o_pready && i_pwrite && i_paddr < DRP_SIZE_OFF ##3 o_pready && !i_pwrite
        && i_paddr == $past(i_paddr, 3) |-> o_prdata[15:10] == $past(i_pwdata[15:10], 3)) else $error("bad base");
    AST_RST: assert property ($rose(i_arst_n) |-> o_access_region == DRP_KDATA && !o_pready) else $error("bad reset");
    AST_RANGE: assert property (1 |=> o_access_out_of_range == ($past(i_access_offset) >= RAM_SIZE))
        else $error("bad range");
    AST_LOW_KD: assert property (i_access_offset < 15'h400 |=> o_access_region == DRP_KDATA) else $error("bad low");
    // Bases only move through the bus, so an idle bus freezes the region
    AST_HOLD: assert property (($stable(i_access_offset) && !i_psel) [*2] |=> $stable(o_access_region))
        else $error("region moved");
endmodule
bind drp_regs drp_regs_asserts #(.RAM_SIZE(RAM_SIZE)) chk_u (.*);

// ---- test/data_ram_partition_regs_test.sv ----
// Self-checking bench for the data RAM partition registers
module data_ram_partition_regs_test
    import drp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    // A 16 KB part puts offset 4000 out of range
    localparam logic [31:0] SIZE = DRP_SIZE_16K;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h0;
    logic [31:0] i_pwdata = 32'h0;
    logic [3:0] i_pstrb = 4'hf;
    logic [14:0] i_access_offset = 15'h0;
    logic [31:0] o_prdata;
    logic [31:0] r;
    logic o_pready;
    logic o_pslverr;
    logic o_access_out_of_range;
    logic se;
    drp_region_e o_access_region;
    int n_errors = 0;
    int samples_checked = 0;
    always #10 i_clk = ~i_clk;
    drp_regs #(.RAM_SIZE(SIZE)) dut_u (.*);
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            n_errors++;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
        end
    endtask
    // The idle cycle at the end keeps psel from being driven twice in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do
            @(posedge i_clk);
        while (o_pready !== 1'b1);
        r = o_prdata;
        se = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        for (int i = 0; i < 4; i++)
        begin
            apb(0, 8'(i * 4), 0);
            chk(r, i == 3 ? SIZE : 0);
        end
        // Field value 4 keeps the base inside the RAM size while high and low bits are driven to one
        apb(1, DRP_KPB_OFF, 32'hffff_13ff);
        apb(0, DRP_KPB_OFF, 0);
        chk(r, 32'h0000_1000);
        apb(1, DRP_SIZE_OFF, 0);
        apb(0, DRP_SIZE_OFF, 0);
        chk(r, SIZE);
        apb(0, 8'h10, 0);
        chk({se, r[30:0]}, 32'h8000_0000);
        for (int i = 1; i < 4; i++)
        begin
            apb(1, 8'(i * 4 - 4), 32'hffff_0000 | (i << 10));
            apb(0, 8'(i * 4 - 4), 0);
            chk(r, i << 10);
        end
        for (int i = 0; i < 5; i++)
        begin
            i_access_offset <= 15'(i < 4 ? i * 1024 : 16384);
            repeat (2) @(posedge i_clk);
            chk({o_access_out_of_range, o_access_region}, i < 4 ? i : 7);
        end
        i_arst_n <= 1'b0;
        @(posedge i_clk);
        i_arst_n <= 1'b1;
        apb(0, DRP_UPB_OFF, 0);
        chk(r, 0);
        chk(o_access_region, DRP_KDATA);
        give_verdict();
    end
    initial
    begin
        repeat (1000) @(posedge i_clk);
        n_errors++;
        give_verdict();
    end
endmodule
